// File: adcsc_consts.svh
// Purpose: Offsets, field positions, reset values and counts of the converter sequencer
// Assumes: 8-bit register port, 8-bit register addresses
// Notes: Definitions only
`ifndef ADCSC_CONSTS_SVH
`define ADCSC_CONSTS_SVH

// ==========================================================
// Register addresses
`define ADCSC_ADDR_CON1 8'hB4
`define ADCSC_ADDR_CON2 8'hB5
`define ADCSC_ADDR_RESH 8'hBB

// ==========================================================
// Field positions, control one
`define ADCSC_EOC_BIT 7
`define ADCSC_ST_BIT 6
`define ADCSC_START_SOURCE_SELECT_HI 5
`define ADCSC_START_SOURCE_SELECT_LO 4
`define ADCSC_RANDOM_STEP_CONTROL_HI 3
`define ADCSC_RANDOM_STEP_CONTROL_LO 2
`define ADCSC_RSV_HI 1
`define ADCSC_RSV_LO 0

// ==========================================================
// Field positions, sequence control
`define ADCSC_SEQUENCE_REFERENCE_SELECT_HI 7
`define ADCSC_SEQUENCE_REFERENCE_SELECT_LO 6
`define ADCSC_SEQUENCE_DECIMATION_SELECT_HI 5
`define ADCSC_SEQUENCE_DECIMATION_SELECT_LO 4
`define ADCSC_SCH_HI 3
`define ADCSC_SCH_LO 0

// ==========================================================
// Reset values
`define ADCSC_RST_RESH 8'h00
`define ADCSC_RST_START_SOURCE_SELECT 2'h3
`define ADCSC_RST_RANDOM_STEP_CONTROL 2'h0
`define ADCSC_RST_RSV 2'h3
`define ADCSC_RST_SEQUENCE_REFERENCE_SELECT 2'h0
`define ADCSC_RST_SEQUENCE_DECIMATION_SELECT 2'h1
`define ADCSC_RST_SCH 4'h0
`define ADCSC_RST_LFSR 16'hFFFF

// ==========================================================
// Codes and counts
`define ADCSC_START_SOURCE_SELECT_PIN 2'h0
`define ADCSC_START_SOURCE_SELECT_FREE 2'h1
`define ADCSC_START_SOURCE_SELECT_TIMER 2'h2
`define ADCSC_START_SOURCE_SELECT_SW 2'h3
`define ADCSC_RANDOM_STEP_CONTROL_STEP 2'h1
`define ADCSC_SCH_LAST_SE 4'h7
`define ADCSC_SCH_FIRST_DIFF 4'h8
`define ADCSC_SCH_FIRST_SINGLE 4'hC
`define ADCSC_SCH_ZERO 4'h0
`define ADCSC_SETTLE_TICKS 10'h010
`define ADCSC_DEC_BASE 10'h040
`define ADCSC_CLK_DIV 6
`define ADCSC_LFSR_STEPS 13
`define ADCSC_LFSR_TAPS 16'h1021

`endif

// File: adcsc_pkg.sv
// Purpose: Types shared by the converter sequencer files
// Assumes: Nothing
// Notes: Constants live in adcsc_consts.svh
package adcsc_pkg;

   // ==========================================================
   // Sequencer state
   typedef enum logic [0:0] {
      ADCSC_IDLE,
      ADCSC_CONV
   } adcsc_state_e;

   // ==========================================================
   // Selection driven to the converter core
   typedef struct packed {
      logic [1:0] reference;
      logic [1:0] decimation;
      logic [3:0] channel;
   } adcsc_sel_s;

endpackage

// File: adcsc_lfsr.sv
// Purpose: 16-bit random generator advanced by several unrolled steps per request
// Assumes: Step request is a one-cycle pulse on i_clock
// Notes: Galois form
`include "adcsc_consts.svh"

module adcsc_lfsr #(
   parameter int STEPS = `ADCSC_LFSR_STEPS,
   parameter logic [15:0] TAPS = `ADCSC_LFSR_TAPS
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_step,
   output logic [15:0] o_value
);
   import adcsc_pkg::*;

   if (STEPS < 1 || STEPS > 64) begin : g_chk
      $error("adcsc_lfsr: STEPS out of range");
   end

   // ==========================================================
   // Unrolled advance
   function automatic logic [15:0] advance(input logic [15:0] v);
      logic [15:0] r;
      r = v;
      for (int k = 0; k < STEPS; k++) begin
         r = r[15] ? ((r << 1) ^ TAPS) : (r << 1);
      end
      return r;
   endfunction

   wire logic [15:0] value_next = advance(o_value);

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_value <= `ADCSC_RST_LFSR;
      end else if (i_step) begin
         o_value <= value_next;
      end
   end

endmodule

// File: adcsc_top.sv
// Purpose: Register file and conversion sequencer of the delta-sigma converter
// Assumes: 50 MHz i_clock, synchronous active-high reset, same-clock core sample input
// Notes: Converter clock is an enable pulse every CLK_DIV system cycles
`include "adcsc_consts.svh"

// Summary of operation
// RQ1 - Result high byte is read-only, resets to zero, shows result bits 11 to 4.
// RQ2 - Done flag in control one bit 7 is read-only, cleared by reading result high.
// RQ3 - A further conversion before that read just keeps the done flag set.
// RQ4 - Writing one to start bit launches a sequence only with software source and idle.
// RQ5 - Start bit reads one while its sequence runs, zero otherwise; writing zero does nothing.
// RQ6 - Start source: 00 pin edge, 01 free running, 10 timer compare, 11 start bit.
// RQ7 - Random control 01 advances the generator by thirteen steps, then returns to 00.
// RQ8 - Software always writes 11 into control one bits 1:0, which reset to 11.
// RQ9 - Reference select: internal, input seven, supply pin, or inputs six and seven.
// RQ10 - Decimation select 64, 128, 256 or 512, giving 7, 9, 10 or 12 bits.
// RQ11 - Only the top resolution bits of the result are valid; lower bits carry nothing.
// RQ12 - Single-ended end code converts inputs zero up to the programmed input.
// RQ13 - Differential end code converts from the first pair up to the programmed pair.
// RQ14 - End code above the pairs makes one single conversion of that source.
// RQ15 - Conversion end sets the done flag and loads the result register.
// RQ16 - Start bit clears itself when its sequence has finished.
// RQ17 - End field reads last converted channel, plus one for codes below 1100.
// RQ18 - Each conversion lasts decimation rate plus 16 converter clock periods.
// RQ19 - End codes map onto eight inputs, four pairs, ground, reference, sensor, supply third.
// RQ20 - Reference, decimation and sequence are sampled when a sequence starts.
module adcsc_top #(
   parameter int CLK_DIV = `ADCSC_CLK_DIV
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_ext_trig,
   input wire logic i_timer_cmp,
   input wire logic [11:0] i_sample,
   output logic [7:0] o_rdata,
   output adcsc_pkg::adcsc_sel_s o_sel,
   output logic o_busy,
   output logic o_settling,
   output logic o_conv_done,
   output logic [15:0] o_random
);
   import adcsc_pkg::*;

   if (CLK_DIV < 2 || CLK_DIV > 255) begin : g_chk
      $error("adcsc_top: CLK_DIV out of range");
   end

   // ==========================================================
   // Helper functions
   function automatic logic [9:0] conv_len(input logic [1:0] div);
      return (`ADCSC_DEC_BASE << div) + `ADCSC_SETTLE_TICKS;
   endfunction

   function automatic logic [11:0] res_mask(input logic [1:0] div);
      logic [11:0] m;
      unique case (div)
         2'h0: m = 12'hFE0;
         2'h1: m = 12'hFF8;
         2'h2: m = 12'hFFC;
         2'h3: m = 12'hFFF;
      endcase
      return m;
   endfunction

   function automatic logic [3:0] first_chan(input logic [3:0] sequence_end_channel);
      logic [3:0] c;
      if (sequence_end_channel <= `ADCSC_SCH_LAST_SE) begin
         c = `ADCSC_SCH_ZERO;
      end else if (sequence_end_channel < `ADCSC_SCH_FIRST_SINGLE) begin
         c = `ADCSC_SCH_FIRST_DIFF;
      end else begin
         c = sequence_end_channel;
      end
      return c;
   endfunction

   // ==========================================================
   // Registers
   logic trig_meta_reg;
   logic trig_sync_reg;
   logic trig_prev_reg;
   logic [7:0] div_cnt_reg;
   adcsc_state_e state_reg;
   logic [9:0] tick_cnt_reg;
   logic [3:0] end_reg;
   logic eoc_reg;
   logic st_reg;
   logic [1:0] start_source_select_reg;
   logic [1:0] random_step_control_reg;
   logic [1:0] rsv_reg;
   logic [1:0] sequence_reference_select_reg;
   logic [1:0] sequence_decimation_select_reg;
   logic [3:0] sch_reg;
   logic [7:0] resh_reg;

   // ==========================================================
   // Port decode
   wire logic wr_con1 = i_wr && (i_addr == `ADCSC_ADDR_CON1);
   wire logic wr_con2 = i_wr && (i_addr == `ADCSC_ADDR_CON2);
   wire logic rd_resh = i_rd && (i_addr == `ADCSC_ADDR_RESH);
   wire logic idle = (state_reg == ADCSC_IDLE);

   // ==========================================================
   // Converter clock enable
   wire logic adc_tick = (div_cnt_reg == 8'(CLK_DIV - 1));

   always_ff @(posedge i_clock) begin
      if (i_rst || adc_tick) begin
         div_cnt_reg <= 8'h00;
      end else begin
         div_cnt_reg <= div_cnt_reg + 8'h01;
      end
   end

   // ==========================================================
   // External trigger synchroniser and edge
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         trig_meta_reg <= 1'b0;
         trig_sync_reg <= 1'b0;
         trig_prev_reg <= 1'b0;
      end else begin
         trig_meta_reg <= i_ext_trig;
         trig_sync_reg <= trig_meta_reg;
         trig_prev_reg <= trig_sync_reg;
      end
   end

   wire logic trig_rise = trig_sync_reg && !trig_prev_reg;

   // ==========================================================
   // Start decision
   wire logic start_sw = wr_con1 && i_wdata[`ADCSC_ST_BIT] &&
                         (start_source_select_reg == `ADCSC_START_SOURCE_SELECT_SW) && idle; // [RQ4]
   wire logic start_pin = (start_source_select_reg == `ADCSC_START_SOURCE_SELECT_PIN) && trig_rise; // [RQ6]
   wire logic start_free = (start_source_select_reg == `ADCSC_START_SOURCE_SELECT_FREE); // [RQ6]
   wire logic start_tmr = (start_source_select_reg == `ADCSC_START_SOURCE_SELECT_TIMER) && i_timer_cmp; // [RQ6]
   wire logic start_go = idle && (start_sw || start_pin || start_free || start_tmr);

   // ==========================================================
   // Conversion timing and sequence stepping
   wire logic conv_end = !idle && adc_tick &&
                         (tick_cnt_reg == conv_len(o_sel.decimation) - 10'h001); // [RQ18]
   wire logic single_mode = (end_reg >= `ADCSC_SCH_FIRST_SINGLE); // [RQ14]
   wire logic seq_last = single_mode || (o_sel.channel == end_reg); // [RQ12] [RQ13]
   wire logic [3:0] sch_report = (o_sel.channel < `ADCSC_SCH_FIRST_SINGLE) ?
                                 o_sel.channel + 4'h1 : o_sel.channel; // [RQ17]
   wire logic [11:0] sample_masked = i_sample & res_mask(o_sel.decimation); // [RQ11]
   wire logic settle_next = (tick_cnt_reg < `ADCSC_SETTLE_TICKS - 10'h001);

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state_reg <= ADCSC_IDLE;
         tick_cnt_reg <= 10'h000;
         end_reg <= `ADCSC_RST_SCH;
         o_sel <= '0;
      end else if (start_go) begin
         state_reg <= ADCSC_CONV;
         tick_cnt_reg <= 10'h000;
         end_reg <= sch_reg; // [RQ20]
         o_sel <= '{sequence_reference_select_reg, sequence_decimation_select_reg, first_chan(sch_reg)}; // [RQ20] [RQ9] [RQ10] [RQ19]
      end else if (conv_end) begin
         tick_cnt_reg <= 10'h000;
         if (seq_last) begin
            state_reg <= ADCSC_IDLE;
         end else begin
            o_sel.channel <= o_sel.channel + 4'h1; // [RQ12] [RQ13]
         end
      end else if (!idle && adc_tick) begin
         tick_cnt_reg <= tick_cnt_reg + 10'h001; // [RQ18]
      end
   end

   // ==========================================================
   // Status outputs
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_busy <= 1'b0;
         o_settling <= 1'b0;
         o_conv_done <= 1'b0;
      end else begin
         o_busy <= start_go || (!idle && !(conv_end && seq_last));
         o_settling <= start_go || (!idle && !conv_end && !(adc_tick && !settle_next) && o_settling) ||
                       (conv_end && !seq_last);
         o_conv_done <= conv_end;
      end
   end

   // ==========================================================
   // Result and done flag
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         resh_reg <= `ADCSC_RST_RESH; // [RQ1]
         eoc_reg <= 1'b0;
      end else begin
         if (conv_end) begin
            resh_reg <= sample_masked[11:4]; // [RQ1] [RQ15]
         end
         if (conv_end) begin
            eoc_reg <= 1'b1; // [RQ15] [RQ3]
         end else if (rd_resh) begin
            eoc_reg <= 1'b0; // [RQ2]
         end
      end
   end

   // ==========================================================
   // Control one
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_reg <= 1'b0;
         start_source_select_reg <= `ADCSC_RST_START_SOURCE_SELECT;
         random_step_control_reg <= `ADCSC_RST_RANDOM_STEP_CONTROL;
         rsv_reg <= `ADCSC_RST_RSV; // [RQ8]
      end else begin
         if (start_go) begin
            st_reg <= start_sw; // [RQ5]
         end else if (conv_end && seq_last) begin
            st_reg <= 1'b0; // [RQ16]
         end
         if (wr_con1) begin
            start_source_select_reg <= i_wdata[`ADCSC_START_SOURCE_SELECT_HI:`ADCSC_START_SOURCE_SELECT_LO];
            rsv_reg <= i_wdata[`ADCSC_RSV_HI:`ADCSC_RSV_LO];
            random_step_control_reg <= i_wdata[`ADCSC_RANDOM_STEP_CONTROL_HI:`ADCSC_RANDOM_STEP_CONTROL_LO];
         end else if (random_step_control_reg == `ADCSC_RANDOM_STEP_CONTROL_STEP) begin
            random_step_control_reg <= `ADCSC_RST_RANDOM_STEP_CONTROL; // [RQ7]
         end
      end
   end

   wire logic lfsr_step = (random_step_control_reg == `ADCSC_RANDOM_STEP_CONTROL_STEP); // [RQ7]

   // ==========================================================
   // Sequence control
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         sequence_reference_select_reg <= `ADCSC_RST_SEQUENCE_REFERENCE_SELECT;
         sequence_decimation_select_reg <= `ADCSC_RST_SEQUENCE_DECIMATION_SELECT;
         sch_reg <= `ADCSC_RST_SCH;
      end else begin
         if (wr_con2) begin
            sequence_reference_select_reg <= i_wdata[`ADCSC_SEQUENCE_REFERENCE_SELECT_HI:`ADCSC_SEQUENCE_REFERENCE_SELECT_LO];
            sequence_decimation_select_reg <= i_wdata[`ADCSC_SEQUENCE_DECIMATION_SELECT_HI:`ADCSC_SEQUENCE_DECIMATION_SELECT_LO];
         end
         if (conv_end) begin
            sch_reg <= sch_report; // [RQ17]
         end else if (wr_con2) begin
            sch_reg <= i_wdata[`ADCSC_SCH_HI:`ADCSC_SCH_LO];
         end
      end
   end

   // ==========================================================
   // Read path
   wire logic [7:0] con1_view = {eoc_reg, st_reg, start_source_select_reg, random_step_control_reg, rsv_reg}; // [RQ2] [RQ5]
   wire logic [7:0] con2_view = {sequence_reference_select_reg, sequence_decimation_select_reg, sch_reg};
   wire logic [7:0] rd_mux = (i_addr == `ADCSC_ADDR_CON1) ? con1_view :
                             (i_addr == `ADCSC_ADDR_CON2) ? con2_view :
                             (i_addr == `ADCSC_ADDR_RESH) ? resh_reg : 8'h00;

   always_ff @(posedge i_clock) begin
      if (i_rst || !i_rd) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= rd_mux;
      end
   end

   // ==========================================================
   // Random generator
   adcsc_lfsr u_lfsr (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_step(lfsr_step),
      .o_value(o_random)
   );

endmodule

// File: adcsc_top_sva.sv
// Purpose: Port checks of the converter sequencer
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to adcsc_top below
`include "adcsc_consts.svh"

module adcsc_chk #(
   parameter int CLK_DIV = `ADCSC_CLK_DIV
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_ext_trig,
   input wire logic i_timer_cmp,
   input wire logic [11:0] i_sample,
   input wire logic [7:0] o_rdata,
   input wire adcsc_pkg::adcsc_sel_s o_sel,
   input wire logic o_busy,
   input wire logic o_settling,
   input wire logic o_conv_done,
   input wire logic [15:0] o_random
);
   import adcsc_pkg::*;
   // ==========================================================
   // Shadow of the start source
   logic [1:0] src_reg;
   logic [1:0] src_next;
   wire logic c1_wr = i_wr && (i_addr == `ADCSC_ADDR_CON1);
   wire logic step_wr = c1_wr && (i_wdata[3:2] == `ADCSC_RANDOM_STEP_CONTROL_STEP);
   wire logic sw_go = c1_wr && i_wdata[6] && (src_reg == `ADCSC_START_SOURCE_SELECT_SW) && !o_busy;
   assign src_next = c1_wr ? i_wdata[5:4] : src_reg;
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         src_reg <= `ADCSC_RST_START_SOURCE_SELECT;
      end else begin
         src_reg <= src_next;
      end
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // ==========================================================
   // Assertions
   property p_rd_idle; !i_rd |=> o_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_eoc_clr;
      (i_rd && i_addr == `ADCSC_ADDR_RESH) ##1 !o_conv_done ##1 (i_rd && i_addr == `ADCSC_ADDR_CON1 && !o_conv_done)
      |=> !o_rdata[7];
   endproperty
   a_eoc_clr: assert property (p_eoc_clr) else $error("done flag kept after result read");
   property p_done_pulse; o_conv_done |=> !o_conv_done; endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done pulse too long");
   property p_done_busy; o_conv_done |-> $past(o_busy); endproperty
   a_done_busy: assert property (p_done_busy) else $error("done without running sequence");
   property p_sw_start; sw_go |=> o_busy; endproperty
   a_sw_start: assert property (p_sw_start) else $error("start bit did not launch");
   property p_no_start; !o_busy && src_reg == `ADCSC_START_SOURCE_SELECT_SW && !(c1_wr && i_wdata[6]) |=> !o_busy; endproperty
   a_no_start: assert property (p_no_start) else $error("sequence without start bit");
   property p_st_idle; i_rd && i_addr == `ADCSC_ADDR_CON1 && !o_busy |=> !o_rdata[6]; endproperty
   a_st_idle: assert property (p_st_idle) else $error("start bit set while idle");
   property p_sel_hold;
      o_busy && $past(o_busy) && $past(o_busy, 2) |-> $stable(o_sel.reference) && $stable(o_sel.decimation);
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("selection changed mid sequence");
   property p_rnd; $changed(o_random) |-> $past(step_wr, 2) || $past(step_wr, 3); endproperty
   a_rnd: assert property (p_rnd) else $error("generator moved without request");
endmodule

bind adcsc_top adcsc_chk #(.CLK_DIV(CLK_DIV)) u_chk (
   .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .i_ext_trig(i_ext_trig), .i_timer_cmp(i_timer_cmp), .i_sample(i_sample), .o_rdata(o_rdata),
   .o_sel(o_sel), .o_busy(o_busy), .o_settling(o_settling), .o_conv_done(o_conv_done), .o_random(o_random)
);

// File: tb_adcsc_top.sv
// Purpose: Self-checking bench of the converter sequencer
// Assumes: Converter clock divider shortened to 2
// Notes: Core sample input held at a fixed pattern
`include "adcsc_consts.svh"

module tb_adcsc_top;
   timeunit 1ns;
   timeprecision 1ps;
   import adcsc_pkg::*;
   localparam logic [7:0] c1_a = `ADCSC_ADDR_CON1;
   localparam logic [7:0] c2_a = `ADCSC_ADDR_CON2;
   localparam logic [7:0] rh_a = `ADCSC_ADDR_RESH;
   logic i_clock, i_rst, i_wr, i_rd, i_ext_trig, i_timer_cmp, o_busy, o_settling, o_conv_done;
   logic [7:0] i_addr, i_wdata, o_rdata;
   logic [11:0] i_sample;
   logic [15:0] o_random;
   adcsc_sel_s o_sel;
   int num_errors = 0;
   int n_checks = 0;
   adcsc_top #(.CLK_DIV(2)) DUT (
      .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .i_ext_trig(i_ext_trig), .i_timer_cmp(i_timer_cmp), .i_sample(i_sample), .o_rdata(o_rdata),
      .o_sel(o_sel), .o_busy(o_busy), .o_settling(o_settling), .o_conv_done(o_conv_done), .o_random(o_random)
   );
   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end
   // ==========================================================
   // Bus and compare tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1;
      chk({8'h00, o_rdata}, {8'h00, e});
   endtask
   task automatic idle_wait(output int n);
      n = 0;
      for (int k = 0; k < 4000; k++) begin
         @(posedge i_clock);
         #1;
         if (o_conv_done === 1'b1) n++;
         if (o_busy === 1'b0) break;
      end
   endtask
   // ==========================================================
   // Scenarios
   task automatic reset_test;
      chk(o_random, `ADCSC_RST_LFSR);
      rd(c1_a, 8'h33);
      rd(c2_a, 8'h10);
      wr(rh_a, 8'hFF);
      rd(rh_a, 8'h00);
      rd(8'hB6, 8'h00);
      $display("reset test done");
   endtask
   task automatic rnd_test;
      logic [15:0] v;
      v = `ADCSC_RST_LFSR;
      for (int k = 0; k < `ADCSC_LFSR_STEPS; k++) v = {v[14:0], 1'b0} ^ (v[15] ? `ADCSC_LFSR_TAPS : 16'h0000);
      wr(c1_a, 8'h37);
      rd(c1_a, 8'h33);
      chk(o_random, v);
      wr(c1_a, 8'h3B);
      rd(c1_a, 8'h3B);
      chk(o_random, v);
      wr(c1_a, 8'h33);
      $display("random test done");
   endtask
   task automatic run_seq(input logic [7:0] c2, input int nconv, input logic [3:0] last, input logic [7:0] res);
      int n;
      wr(c2_a, c2);
      wr(c1_a, 8'h73);
      #1;
      chk({15'h0000, o_busy}, 16'h0001);
      chk({15'h0000, o_settling}, 16'h0001);
      rd(c1_a, 8'h73);
      chk({8'h00, o_sel}, {8'h00, c2[7:4], (c2[3:0] < 4'h8) ? 4'h0 : (c2[3:0] < 4'hC) ? 4'h8 : c2[3:0]});
      idle_wait(n);
      chk(n[15:0], nconv[15:0]);
      rd(c2_a, {c2[7:4], last});
      rd(c1_a, 8'hB3);
      rd(rh_a, res);
      rd(c1_a, 8'h33);
      $display("sequence test %h done", c2);
   endtask
   task automatic trig(input logic [1:0] code);
      int n;
      wr(c1_a, {2'b00, code, 4'h3});
      wr(c1_a, {2'b01, code, 4'h3});
      repeat (4) @(posedge i_clock);
      #1;
      chk({15'h0000, o_busy}, {15'h0000, code == `ADCSC_START_SOURCE_SELECT_FREE});
      @(posedge i_clock);
      i_ext_trig <= (code == `ADCSC_START_SOURCE_SELECT_PIN);
      i_timer_cmp <= (code == `ADCSC_START_SOURCE_SELECT_TIMER);
      @(posedge i_clock);
      i_timer_cmp <= 1'b0;
      repeat (6) @(posedge i_clock);
      i_ext_trig <= 1'b0;
      #1;
      chk({15'h0000, o_busy}, 16'h0001);
      wr(c1_a, 8'h33);
      idle_wait(n);
      rd(c1_a, 8'hB3);
      rd(rh_a, 8'hA5);
      $display("trigger test %h done", code);
   endtask
   // ==========================================================
   // Run control
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge i_clock);
      num_errors++;
      tally_and_finish;
   end
   initial begin
      i_rst = 1'b1;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_ext_trig = 1'b0;
      i_timer_cmp = 1'b0;
      i_sample = 12'hA5F;
      repeat (3) @(posedge i_clock);
      i_rst <= 1'b0;
      reset_test;
      rnd_test;
      run_seq(8'h02, 3, 4'h3, 8'hA4);
      run_seq(8'hF9, 2, 4'hA, 8'hA5);
      run_seq(8'h6E, 1, 4'hE, 8'hA5);
      run_seq(8'h9C, 1, 4'hC, 8'hA5);
      trig(`ADCSC_START_SOURCE_SELECT_PIN);
      trig(`ADCSC_START_SOURCE_SELECT_FREE);
      trig(`ADCSC_START_SOURCE_SELECT_TIMER);
      tally_and_finish;
   end
endmodule
